/* src/condition_select.sv */
// evaluates the condition of a conditional branch
`timescale 1ns/1ps

module condition_select
   import flow_ctrl_pkg::*;
(
   // instruction and register
   input wire flow_op_e flow_i,
   input wire logic [15:0] count_i,
   input wire logic split_i,
   // event sources
   input wire cond_src_s src_i,
   // result
   output logic cond_o,
   output logic is_cond_o
);

   // ==========================================================
   // condition decode
   always_comb
   begin
      cond_o = 1'b0;
      is_cond_o = 1'b1;
      case (flow_i)
         // split halves offered only in split mode
         FLOW_IF_RA: cond_o = split_i && (count_i[7:0] == 8'h00);
         FLOW_IF_RB: cond_o = split_i && (count_i[15:8] == 8'h00);
         // whole register offered only in combined mode
         FLOW_IF_R: cond_o = !split_i && (count_i == 16'h0000);
         FLOW_IF_IRQ: cond_o = src_i.irq_pend;
         FLOW_IF_EXT: cond_o = src_i.ext;
         FLOW_IF_KEY: cond_o = src_i.key;
         FLOW_IF_FULL: cond_o = src_i.full;
         FLOW_IF_END: cond_o = src_i.done;
         default: is_cond_o = 1'b0;
      endcase
   end

endmodule

/* src/flow_ctrl_cfg.svh */
// offsets, field positions, reset values and timing counts of the flow controller
`ifndef FLOW_CTRL_CFG_SVH
`define FLOW_CTRL_CFG_SVH

// ==========================================================
// register byte offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_PROG_ADDR  8'h08
`define REG_PROG_LO    8'h0c
`define REG_PROG_HI    8'h10
`define REG_COUNT      8'h14
`define REG_KEY        8'h18
`define REG_IRQ_STAT   8'h1c
`define REG_IRQ_EN     8'h20
`define REG_IRQ_CLR    8'h24
`define REG_CALL_DEST  8'h28

// ==========================================================
// control register bit positions
`define CTRL_RUN_START 0
`define CTRL_SPLIT     1
`define CTRL_RELOAD    2
`define CTRL_CALL_MODE 3
`define CTRL_KEY_PRESS 4

// ==========================================================
// program word field positions
`define LO_STROBE_LSB  16
`define LO_MASK_BIT    18
`define HI_DEST_LSB    4
`define HI_TRIG_BIT    14
`define HI_PAGE_BIT    15

// ==========================================================
// reset values, limits and key codes
`define CTRL_RESET     5'h00
`define LAST_LINE      10'h3ff
`define KEY_CODE_FULL  8'h2f
`define KEY_CODE_END   8'h2e

// ==========================================================
// timing: 40 MHz system clock, one program line per 100 ns
`define CLK_PERIOD_NS  25
`define LINE_PERIOD_NS 100
`define STEP_DIV       (`LINE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* src/flow_ctrl_pkg.sv */
// types shared by the flow controller and its condition selector
package flow_ctrl_pkg;

   // ==========================================================
   // branch instruction field encodings
   typedef enum logic [3:0] {
      FLOW_NONE    = 4'h0,
      FLOW_HALT    = 4'h1,
      FLOW_JUMP    = 4'h2,
      FLOW_IF_RA   = 4'h3,
      FLOW_IF_RB   = 4'h4,
      FLOW_IF_R    = 4'h5,
      FLOW_IF_IRQ  = 4'h6,
      FLOW_IF_EXT  = 4'h7,
      FLOW_IF_KEY  = 4'h8,
      FLOW_IF_FULL = 4'h9,
      FLOW_IF_END  = 4'ha,
      FLOW_RETURN  = 4'hb,
      FLOW_SERVICE = 4'hc
   } flow_op_e;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_RUN    = 3'b010,
      ST_HALTED = 3'b100
   } seq_state_e;

   // ==========================================================
   // one stored program line
   typedef struct packed {
      logic page;
      logic trigger;
      logic [9:0] dest;
      flow_op_e flow;
      logic mask;
      logic [1:0] strobe;
      logic [15:0] pattern;
   } prog_line_s;

   // condition sources seen by the selector
   typedef struct packed {
      logic irq_pend;
      logic ext;
      logic key;
      logic full;
      logic done;
   } cond_src_s;

endpackage

/* src/pattern_sequence_flow_control.sv */
// sequence flow and control instruction logic of the pattern generator
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"

// Summary of operation
// - plain line outputs then advances
// - runs all 1024 lines then stops
// - halt emits line outputs, then stops
// - halt on first line gives no clock
// - jump loads destination, continues onward
// - conditional jump only when condition true
// - split half zero test branches
// - combined 16-bit zero test branches
// - register split or combined mode
// - page advance only with reload off
// - trigger line drives trigger pulse
// - one flow plus two control instructions
// - all line instructions run, fixed order
// - irq test true on captured edge
// - mask bit ignores interrupt requests
// - return resumes after interrupted line
// - external branch input test
// - host key codes 47, 46 set flags
module pattern_sequence_flow_control
   import flow_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   // control probe inputs
   input wire logic irq_req_i,
   input wire logic external_branch_input_i,
   // pattern outputs
   output logic [15:0] pattern_o,
   output logic [1:0] strobe_o,
   output logic out_clock_o,
   // control outputs
   output logic trigger_o,
   output logic page_advance_o,
   output logic host_service_request_o,
   output logic irq_o
);

   // ==========================================================
   // storage and state
   prog_line_s prog_mem [0:1023]; // program lines
   prog_line_s line; // line at the program counter
   prog_line_s wr_line; // line being written
   seq_state_e state_q;
   logic [9:0] pc_q; // program counter
   logic [9:0] pc_d;
   logic [9:0] ret_q; // return address
   logic [9:0] prog_addr_q; // program write pointer
   logic [18:0] lo_q; // held low word
   logic [4:0] ctrl_q; // control bits
   logic [15:0] count_q; // internal register
   logic [9:0] call_dest_q; // service routine line
   logic [7:0] div_q; // line rate divider
   logic step; // one line executes
   logic first_q; // first line of the run
   logic irq_prev_q; // last irq sample
   logic irq_pend_q; // captured irq edge
   logic key_q, full_q, done_q; // software flags
   logic [4:0] ev_stat_q, ev_en_q, ev; // interrupt bits
   logic cond, is_cond, call_take, halt_d, run_start;
   logic [31:0] rd_d;
   cond_src_s src;

   assign line = prog_mem[pc_q];
   assign run_start = wr_i && (addr_i == `REG_CTRL) && wr_data_i[`CTRL_RUN_START];

   // ==========================================================
   // line rate divider, one enable pulse per program line
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         div_q <= 8'h00;
      else if (run_start || div_q == 8'(`STEP_DIV - 1))
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end
   assign step = (state_q == ST_RUN) && (div_q == 8'(`STEP_DIV - 1));

   // ==========================================================
   // program memory loading
   always_comb
   begin
      wr_line.pattern = lo_q[15:0];
      wr_line.strobe = lo_q[`LO_STROBE_LSB +: 2];
      wr_line.mask = lo_q[`LO_MASK_BIT];
      wr_line.flow = flow_op_e'(wr_data_i[3:0]);
      wr_line.dest = wr_data_i[`HI_DEST_LSB +: 10];
      wr_line.trigger = wr_data_i[`HI_TRIG_BIT];
      wr_line.page = wr_data_i[`HI_PAGE_BIT];
   end

   // high word write stores the line and steps the pointer
   always_ff @(posedge clock_i)
   begin
      if (wr_i && addr_i == `REG_PROG_HI)
         prog_mem[prog_addr_q] <= wr_line;
   end

   // write pointer and held low word
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prog_addr_q <= 10'h000;
         lo_q <= 19'h00000;
      end
      else if (wr_i && addr_i == `REG_PROG_ADDR)
         prog_addr_q <= wr_data_i[9:0];
      else if (wr_i && addr_i == `REG_PROG_LO)
         lo_q <= wr_data_i[18:0];
      else if (wr_i && addr_i == `REG_PROG_HI)
         prog_addr_q <= prog_addr_q + 10'h001;
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q <= `CTRL_RESET;
         count_q <= 16'h0000;
         call_dest_q <= 10'h000;
         ev_en_q <= 5'h00;
      end
      else if (wr_i)
      begin
         case (addr_i)
            `REG_CTRL: ctrl_q <= wr_data_i[4:0];
            `REG_COUNT: count_q <= wr_data_i[15:0];
            `REG_CALL_DEST: call_dest_q <= wr_data_i[9:0];
            `REG_IRQ_EN: ev_en_q <= wr_data_i[4:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // condition sources; probe lines are discounted on the first line
   assign src.irq_pend = irq_pend_q && !first_q;
   assign src.ext = external_branch_input_i && !first_q;
   assign src.key = key_q;
   assign src.full = full_q;
   assign src.done = done_q;

   condition_select u_cond (
      .flow_i(line.flow),
      .count_i(count_q),
      .split_i(ctrl_q[`CTRL_SPLIT]),
      .src_i(src),
      .cond_o(cond),
      .is_cond_o(is_cond)
   );

   // interrupt call: enabled, pending, line not masked and not a halt
   assign call_take = ctrl_q[`CTRL_CALL_MODE] && src.irq_pend && !line.mask
      && line.flow != FLOW_HALT;

   // ==========================================================
   // next line selection; control outputs first, flow last
   always_comb
   begin
      pc_d = pc_q + 10'h001;
      halt_d = 1'b0;
      case (line.flow)
         FLOW_HALT: halt_d = 1'b1;
         FLOW_JUMP: pc_d = line.dest;
         FLOW_RETURN: pc_d = ret_q;
         default:
            if (is_cond && cond)
               pc_d = line.dest;
      endcase
      if (call_take)
         pc_d = call_dest_q;
      else if (pc_q == `LAST_LINE && !halt_d && !(is_cond && cond)
         && line.flow != FLOW_JUMP && line.flow != FLOW_RETURN)
         halt_d = 1'b1;
   end

   // ==========================================================
   // sequencer state and program counter
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_q <= ST_IDLE;
         pc_q <= 10'h000;
         ret_q <= 10'h000;
         first_q <= 1'b0;
      end
      else if (run_start)
      begin
         // restart from line zero
         state_q <= ST_RUN;
         pc_q <= 10'h000;
         first_q <= 1'b1;
      end
      else if (step)
      begin
         first_q <= 1'b0;
         if (call_take)
            ret_q <= pc_q + 10'h001;
         if (halt_d)
            state_q <= ST_HALTED;
         else
            pc_q <= pc_d;
      end
   end

   // ==========================================================
   // line outputs: pattern, strobe, clock and control pulses
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pattern_o <= 16'h0000;
         strobe_o <= 2'h0;
         out_clock_o <= 1'b0;
         trigger_o <= 1'b0;
         page_advance_o <= 1'b0;
         host_service_request_o <= 1'b0;
      end
      else
      begin
         out_clock_o <= 1'b0;
         trigger_o <= 1'b0;
         page_advance_o <= 1'b0;
         host_service_request_o <= 1'b0;
         if (step)
         begin
            pattern_o <= line.pattern;
            strobe_o <= line.strobe;
            // no clock edge for a halt on the first line
            out_clock_o <= !(first_q && line.flow == FLOW_HALT);
            trigger_o <= line.trigger;
            page_advance_o <= line.page && !ctrl_q[`CTRL_RELOAD];
            host_service_request_o <= line.flow == FLOW_SERVICE && ctrl_q[`CTRL_RELOAD];
         end
      end
   end

   // ==========================================================
   // interrupt request edge capture, cleared at run start
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         irq_prev_q <= 1'b0;
         irq_pend_q <= 1'b0;
      end
      else
      begin
         irq_prev_q <= irq_req_i;
         if (run_start)
            irq_pend_q <= 1'b0;
         else if (irq_req_i && !irq_prev_q)
            irq_pend_q <= 1'b1;
         else if (step && (call_take || (line.flow == FLOW_IF_IRQ && cond)))
            irq_pend_q <= 1'b0;
      end
   end

   // ==========================================================
   // key and host flags; a new set wins over consumption
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         key_q <= 1'b0;
         full_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         if (wr_i && addr_i == `REG_CTRL && wr_data_i[`CTRL_KEY_PRESS])
            key_q <= 1'b1;
         else if (step && line.flow == FLOW_IF_KEY && cond)
            key_q <= 1'b0;
         if (wr_i && addr_i == `REG_KEY && wr_data_i[7:0] == `KEY_CODE_FULL)
            full_q <= 1'b1;
         else if (step && line.flow == FLOW_IF_FULL && cond)
            full_q <= 1'b0;
         if (wr_i && addr_i == `REG_KEY && wr_data_i[7:0] == `KEY_CODE_END)
            done_q <= 1'b1;
         else if (step && line.flow == FLOW_IF_END && cond)
            done_q <= 1'b0;
      end
   end

   // ==========================================================
   // event status: halted, trigger, page, service, irq call
   assign ev = {step && call_take, host_service_request_o, page_advance_o, trigger_o,
      step && halt_d};

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ev_stat_q <= 5'h00;
      else if (wr_i && addr_i == `REG_IRQ_CLR)
         ev_stat_q <= (ev_stat_q & ~wr_data_i[4:0]) | ev;
      else
         ev_stat_q <= ev_stat_q | ev;
   end
   assign irq_o = |(ev_stat_q & ev_en_q);

   // ==========================================================
   // read data, one cycle after the read strobe
   always_comb
   begin
      rd_d = 32'h00000000;
      case (addr_i)
         `REG_CTRL: rd_d = {27'h0000000, ctrl_q & 5'h0e};
         `REG_STATUS: rd_d = {19'h00000, state_q, pc_q};
         `REG_PROG_ADDR: rd_d = {22'h000000, prog_addr_q};
         `REG_COUNT: rd_d = {16'h0000, count_q};
         `REG_KEY: rd_d = {29'h00000000, key_q, full_q, done_q};
         `REG_IRQ_STAT: rd_d = {27'h0000000, ev_stat_q};
         `REG_IRQ_EN: rd_d = {27'h0000000, ev_en_q};
         `REG_CALL_DEST: rd_d = {22'h000000, call_dest_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rd_data_o <= 32'h00000000;
      else if (rd_i)
         rd_data_o <= rd_d;
      else
         rd_data_o <= 32'h00000000;
   end

   // ==========================================================
   // checks on the sequencer
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   seq_advance_a: assert property (step && line.flow == FLOW_NONE && !call_take
      && pc_q != `LAST_LINE && !run_start |=> pc_q == $past(pc_q) + 10'h001
      && pattern_o == $past(line.pattern))
      else $error("plain line did not advance");
   end_stop_a: assert property (step && line.flow == FLOW_NONE && !call_take
      && pc_q == `LAST_LINE && !run_start |=> state_q == ST_HALTED)
      else $error("last line did not stop");
   halt_stops_a: assert property (step && line.flow == FLOW_HALT && !run_start
      |=> state_q == ST_HALTED && strobe_o == $past(line.strobe) ##1 !step)
      else $error("halt did not stop");
   first_halt_a: assert property (step && first_q && line.flow == FLOW_HALT
      |=> !out_clock_o && pattern_o == $past(line.pattern))
      else $error("clock on first line halt");
   jump_dest_a: assert property (step && line.flow == FLOW_JUMP && !call_take
      && !run_start |=> pc_q == $past(line.dest))
      else $error("jump missed destination");
   cond_fall_a: assert property (step && is_cond && !cond && !call_take
      && pc_q != `LAST_LINE && !run_start |=> pc_q == $past(pc_q) + 10'h001)
      else $error("false condition branched");
   ra_zero_a: assert property (step && line.flow == FLOW_IF_RA && ctrl_q[1]
      && count_q[7:0] == 8'h00 && !call_take && !run_start |=> pc_q == $past(line.dest))
      else $error("zero half did not branch");
   trig_pulse_a: assert property (step && line.trigger |=> trigger_o ##1 !trigger_o)
      else $error("trigger pulse wrong");
   page_gate_a: assert property (page_advance_o |-> $past(!ctrl_q[2] && line.page))
      else $error("page advance in reload mode");
   mask_call_a: assert property (step && line.mask && line.flow == FLOW_NONE
      && pc_q != `LAST_LINE && !run_start |=> pc_q == $past(pc_q) + 10'h001)
      else $error("masked line took interrupt");

   halt_seen_c: cover property (step && line.flow == FLOW_HALT);
   call_return_c: cover property (step && call_take ##[1:400] step && line.flow == FLOW_RETURN);
   cond_taken_c: cover property (step && is_cond && cond);

endmodule

/* testbench/probe_model.sv */
// far-side model: control probe inputs and the pattern receiver
`timescale 1ns/1ps

module probe_model
(
   // clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // commands from the bench
   input wire logic clear_i,
   input wire logic irq_fire_i,
   input wire logic ext_level_i,
   input wire logic [15:0] watch_i,
   // outputs of the generator
   input wire logic out_clock_i,
   input wire logic [15:0] pattern_i,
   input wire logic trigger_i,
   input wire logic page_i,
   input wire logic service_i,
   // probe lines toward the generator
   output logic irq_req_o,
   output logic ext_o,
   // tallies
   output logic [15:0] clocks_o,
   output logic [15:0] hits_o,
   output logic [3:0] trigs_o,
   output logic [3:0] pages_o,
   output logic [3:0] svcs_o
);
   logic [1:0] irq_q; // request width counter

   // ==========================================================
   // probe lines: one clean rising edge held two cycles, level follows bench
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         irq_q <= 2'h0;
         ext_o <= 1'b0;
      end
      else
      begin
         irq_q <= irq_fire_i ? 2'h2 : irq_q - {1'b0, irq_q != 2'h0};
         ext_o <= ext_level_i;
      end
   end
   assign irq_req_o = (irq_q != 2'h0);

   // ==========================================================
   // receiver: counts clocked lines, watched patterns and control pulses
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i || clear_i)
      begin
         clocks_o <= 16'h0;
         hits_o <= 16'h0;
         trigs_o <= 4'h0;
         pages_o <= 4'h0;
         svcs_o <= 4'h0;
      end
      else
      begin
         clocks_o <= clocks_o + {15'h0, out_clock_i};
         hits_o <= hits_o + {15'h0, out_clock_i && pattern_i === watch_i};
         trigs_o <= trigs_o + {3'h0, trigger_i};
         pages_o <= pages_o + {3'h0, page_i};
         svcs_o <= svcs_o + {3'h0, service_i};
      end
   end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the pattern sequence flow controller
`timescale 1ns/1ps
`include "flow_ctrl_cfg.svh"

module tb_top;
   import flow_ctrl_pkg::*;

   // ==========================================================
   // design signals
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rd_data_o;
   logic irq_req_i, ext_in, out_clock_o, trigger_o, page_o, svc_o, irq_o;
   logic [15:0] pattern_o;
   logic [1:0] strobe_o;
   // model controls and tallies
   logic clear_q = 1'b0, fire_q = 1'b0, ext_q = 1'b0;
   logic [15:0] watch_q = 16'h0;
   logic [15:0] clocks, hits;
   logic [3:0] trigs, pages, svcs;
   logic [31:0] v; // read-back value
   int n_fail = 0;
   int checks_done = 0;

   always #12.5 clock_i = ~clock_i;

   pattern_sequence_flow_control uut (.clock_i(clock_i), .resetn_i(resetn_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .irq_req_i(irq_req_i), .external_branch_input_i(ext_in),
      .pattern_o(pattern_o), .strobe_o(strobe_o), .out_clock_o(out_clock_o),
      .trigger_o(trigger_o), .page_advance_o(page_o), .host_service_request_o(svc_o),
      .irq_o(irq_o));

   probe_model model (.clock_i(clock_i), .resetn_i(resetn_i), .clear_i(clear_q),
      .irq_fire_i(fire_q), .ext_level_i(ext_q), .watch_i(watch_q),
      .out_clock_i(out_clock_o), .pattern_i(pattern_o), .trigger_i(trigger_o),
      .page_i(page_o), .service_i(svc_o), .irq_req_o(irq_req_i), .ext_o(ext_in),
      .clocks_o(clocks), .hits_o(hits), .trigs_o(trigs), .pages_o(pages), .svcs_o(svcs));

   // ==========================================================
   // verdict and comparison
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ==========================================================
   // register port cycles: one-cycle strobes after the edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      // let the written register settle before any check looks at it
      #1;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
   endtask

   task rst();
      resetn_i <= 1'b0;
      repeat (16) @(posedge clock_i);
      resetn_i <= 1'b1;
   endtask

   // stores one line: address, low word, then high word
   task prog(input logic [9:0] line, input logic [31:0] lo, input logic [31:0] hi);
      wr(`REG_PROG_ADDR, {22'h0, line});
      wr(`REG_PROG_LO, lo);
      wr(`REG_PROG_HI, hi);
   endtask

   // starts a run, makes one side write, waits for the halted state
   task run(input logic [31:0] mode, input logic [7:0] aa, input logic [31:0] ad,
      input logic fire);
      logic [31:0] s;
      int i;
      wr(`REG_CTRL, mode | 32'h1);
      clear_q <= 1'b1;
      fire_q <= fire;
      wr(aa, ad);
      clear_q <= 1'b0;
      fire_q <= 1'b0;
      for (i = 0; i < 3000; i++)
      begin
         rd(`REG_STATUS, s);
         if (s[12:10] === 3'b100)
            break;
      end
      if (i == 3000)
      begin
         n_fail++;
         wrap_up();
      end
   endtask

   // one conditional branch on line 1: taken lands on line 5, else line 2
   task cc(input logic [31:0] mode, input logic [15:0] cnt, input logic [3:0] fl,
      input logic [7:0] aa, input logic [31:0] ad, input logic fire, input logic ext,
      input logic [15:0] exp);
      wr(`REG_COUNT, {16'h0, cnt});
      prog(10'h1, 32'h1, {16'h0, 12'h005, fl});
      ext_q <= ext;
      run(mode, aa, ad, fire);
      chk({16'h0, pattern_o}, {16'h0, exp});
      ext_q <= 1'b0;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      int i;
      rst();
      rd(`REG_STATUS, v);
      chk(v, 32'h400);
      rd(8'hfc, v);
      chk(v, 32'h0);
      // all lines plain: runs straight through and stops
      wr(`REG_PROG_ADDR, 32'h0);
      for (i = 0; i < 1024; i++)
      begin
         wr(`REG_PROG_LO, i);
         wr(`REG_PROG_HI, 32'h0);
      end
      run(32'h0, 8'hfc, 32'h0, 1'b0);
      chk({16'h0, clocks}, 32'd1024);
      chk({16'h0, pattern_o}, 32'h3ff);
      $display("test full run done");
      // jump over line 2, halt with trigger and page on line 3
      wr(`REG_IRQ_CLR, 32'h1f);
      wr(`REG_IRQ_EN, 32'h0);
      watch_q <= 16'hdead;
      prog(10'h0, 32'h11111, 32'h0);
      prog(10'h1, 32'h2222, 32'h32);
      prog(10'h2, 32'hdead, 32'h0);
      prog(10'h3, 32'h23333, 32'hc001);
      run(32'h0, 8'hfc, 32'h0, 1'b0);
      chk({16'h0, clocks}, 32'd3);
      chk({16'h0, hits}, 32'h0);
      chk({14'h0, strobe_o, pattern_o}, 32'h23333);
      chk({pages, trigs}, 8'h11);
      rd(`REG_IRQ_STAT, v);
      chk(v, 32'h7);
      chk(irq_o, 1'b0);
      wr(`REG_IRQ_EN, 32'h2);
      chk(irq_o, 1'b1);
      wr(`REG_IRQ_CLR, 32'h2);
      chk(irq_o, 1'b0);
      wr(`REG_IRQ_EN, 32'h0);
      $display("test jump and halt done");
      // halt on the first line: outputs but no clock edge
      prog(10'h0, 32'h35a5a, 32'h1);
      run(32'h0, 8'hfc, 32'h0, 1'b0);
      chk({16'h0, clocks}, 32'h0);
      chk({14'h0, strobe_o, pattern_o}, 32'h35a5a);
      $display("test first line halt done");
      // conditional branches
      prog(10'h0, 32'h0, 32'h0);
      prog(10'h2, 32'h2, 32'h1);
      prog(10'h5, 32'h5, 32'h1);
      cc(32'h2, 16'h0100, FLOW_IF_RA, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h5);
      cc(32'h2, 16'h0100, FLOW_IF_RB, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h2, 16'h0000, FLOW_IF_R, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0000, FLOW_IF_R, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h5);
      cc(32'h0, 16'h8000, FLOW_IF_R, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0000, FLOW_IF_RA, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0, FLOW_IF_EXT, 8'hfc, 32'h0, 1'b0, 1'b1, 16'h5);
      cc(32'h0, 16'h0, FLOW_IF_EXT, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0, FLOW_IF_KEY, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0, FLOW_IF_KEY, `REG_CTRL, 32'h10, 1'b0, 1'b0, 16'h5);
      cc(32'h0, 16'h0, FLOW_IF_FULL, `REG_KEY, 32'h2f, 1'b0, 1'b0, 16'h5);
      cc(32'h0, 16'h0, FLOW_IF_END, `REG_KEY, 32'h2e, 1'b0, 1'b0, 16'h5);
      cc(32'h0, 16'h0, FLOW_IF_FULL, `REG_KEY, 32'h2e, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0, FLOW_IF_IRQ, 8'hfc, 32'h0, 1'b0, 1'b0, 16'h2);
      cc(32'h0, 16'h0, FLOW_IF_IRQ, 8'hfc, 32'h0, 1'b1, 1'b0, 16'h5);
      $display("test conditions done");
      // reload mode: page command held back, service request issued
      prog(10'h0, 32'h0, 32'h8000);
      prog(10'h1, 32'h1, 32'hc);
      run(32'h4, 8'hfc, 32'h0, 1'b0);
      chk({pages, svcs}, 8'h01);
      $display("test reload mode done");
      // interrupt call into line 8, return resumes the main flow
      rst();
      wr(`REG_CALL_DEST, 32'h8);
      prog(10'h0, 32'h0, 32'h0);
      prog(10'h1, 32'h40001, 32'h0);
      prog(10'h2, 32'h2, 32'h1);
      prog(10'h8, 32'h0808, 32'hb);
      watch_q <= 16'h0808;
      // masked line 1 holds the request off until the halt on line 2
      run(32'h8, 8'hfc, 32'h0, 1'b1);
      chk({16'h0, hits}, 32'h0);
      prog(10'h1, 32'h1, 32'h0);
      run(32'h8, 8'hfc, 32'h0, 1'b1);
      chk({16'h0, hits}, 32'h1);
      chk({16'h0, pattern_o}, 32'h2);
      $display("test interrupt call done");
      wrap_up();
   end
endmodule
